// ---- hdl/qpsm_pins.sv ----
`timescale 1ns/1ps
module qpsm_pins
  import qpsm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [qpsm_pkg::QPSM_PORTS-1:0] link_lost,
  input wire logic [qpsm_pkg::QPSM_PORTS-1:0] jabber,
  input wire logic [qpsm_pkg::QPSM_EVT_W-1:0] int_clear,
  output logic [qpsm_pkg::QPSM_EVT_W-1:0] int_pending,
  input wire logic mgmt_data_tx,
  input wire logic mgmt_data_tx_en,
  output logic mgmt_data_rx,
  output logic mgmt_enabled,
  output logic rxd_idle_high,
  output logic strap_done,
  input wire logic mode_strap_pin,
  input wire logic mdio_pin_in,
  output qpsm_pkg::qpsm_pin_s mdio_pin,
  output qpsm_pkg::qpsm_pin_s int_pin,
  input wire logic link1_pin_in,
  output qpsm_pkg::qpsm_pin_s link1_pin,
  output logic link2_pin
);
  import qpsm_pkg::*;

  // ----------------------------------------------------------------
  // pad input synchronisers
  // ----------------------------------------------------------------
  // bit 2 mode strap, bit 1 port 1 strap, bit 0 data pin
  logic [2:0] pad_sync;

  qpsm_sync #(
    .WIDTH(3)
  ) u_pad_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in({mode_strap_pin, link1_pin_in, mdio_pin_in}),
    .sync_out(pad_sync)
  );

  // ----------------------------------------------------------------
  // strap sequencer
  // ----------------------------------------------------------------
  qpsm_state_e state_reg; // where the strap capture stands
  qpsm_state_e state_next;
  logic [1:0] settle_reg; // counts synchroniser fill after release
  logic [1:0] settle_next;
  logic mgmt_en_reg; // latched management mode
  logic idle_high_reg; // latched receive idle level
  wire run = (state_reg == QPSM_ST_RUN);
  wire sample = (state_reg == QPSM_ST_SAMPLE);
  wire settled = (settle_reg == QPSM_STRAP_SETTLE);

  // next state: wait for the synchroniser, sample once, then run
  always_comb begin
    state_next = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      QPSM_ST_WAIT: begin
        settle_next = settle_reg + 2'h1;
        if (settled) begin
          settle_next = settle_reg;
          state_next = QPSM_ST_SAMPLE;
        end
      end
      QPSM_ST_SAMPLE: begin
        state_next = QPSM_ST_RUN;
      end
      QPSM_ST_RUN: begin
        state_next = QPSM_ST_RUN;
      end
      default: begin
        state_next = QPSM_ST_WAIT;
        settle_next = 2'h0;
      end
    endcase
  end

  // async reset cannot take a pad value, so straps are caught just after release
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= QPSM_ST_WAIT;
      settle_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      settle_reg <= settle_next;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mgmt_en_reg <= QPSM_MGMT_EN_RST;
      idle_high_reg <= QPSM_IDLE_HIGH_RST;
    end else if (sample) begin
      mgmt_en_reg <= pad_sync[2];
      idle_high_reg <= ~pad_sync[1];
    end
  end

  assign mgmt_enabled = mgmt_en_reg;
  assign rxd_idle_high = idle_high_reg;
  assign strap_done = run;
  assign mgmt_data_rx = pad_sync[0];

  // ----------------------------------------------------------------
  // interrupt causes
  // ----------------------------------------------------------------
  logic [QPSM_PORTS-1:0] link_prev_reg; // last link state seen
  logic [QPSM_PORTS-1:0] jab_prev_reg; // last jabber state seen
  logic [QPSM_EVT_W-1:0] pend_next;
  wire [QPSM_PORTS-1:0] link_chg = link_lost ^ link_prev_reg;
  wire [QPSM_PORTS-1:0] jab_rise = jabber & ~jab_prev_reg;
  wire [QPSM_EVT_W-1:0] evt_set = {jab_rise, link_chg};

  assign pend_next = (int_pending & ~int_clear) | evt_set;

  // edge history and sticky pending bits
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      link_prev_reg <= QPSM_LINK_RST;
      jab_prev_reg <= QPSM_LINK_RST;
      int_pending <= QPSM_PEND_RST;
    end else begin
      link_prev_reg <= link_lost;
      jab_prev_reg <= jabber;
      int_pending <= pend_next;
    end
  end

  // ----------------------------------------------------------------
  // pad output selection
  // ----------------------------------------------------------------
  qpsm_pin_s mdio_next;
  qpsm_pin_s int_next;
  qpsm_pin_s link1_next;
  wire irq_any = |pend_next;

  // port 4 status on data pin when management is off, else management drive
  assign mdio_next = !run ? QPSM_PIN_RELEASED :
                     mgmt_en_reg ? qpsm_pin_s'{out: mgmt_data_tx, oe_n: ~mgmt_data_tx_en} :
                     qpsm_pin_s'{out: link_lost[3], oe_n: 1'b0};

  // port 3 status on interrupt pin when management is off, else open-drain pending interrupt
  assign int_next = !run ? QPSM_PIN_RELEASED :
                    mgmt_en_reg ? qpsm_pin_s'{out: 1'b0, oe_n: ~irq_any} :
                    qpsm_pin_s'{out: link_lost[2], oe_n: 1'b0};

  // port 1 driven after its strap is read
  assign link1_next = run ? qpsm_pin_s'{out: link_lost[0], oe_n: 1'b0} : QPSM_PIN_RELEASED;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mdio_pin <= QPSM_PIN_RELEASED;
      int_pin <= QPSM_PIN_RELEASED;
      link1_pin <= QPSM_PIN_RELEASED;
      link2_pin <= 1'b0;
    end else begin
      mdio_pin <= mdio_next;
      int_pin <= int_next;
      link1_pin <= link1_next;
      link2_pin <= link_lost[1];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // management drive
  mdio_mgmt_a: assert property (@(posedge mclk) disable iff (reset)
    (run && mgmt_en_reg) |=> (mdio_pin.oe_n == !$past(mgmt_data_tx_en)) &&
      (mdio_pin.out == $past(mgmt_data_tx)))
    else $error("data pin not following management drive");

  link4_status_a: assert property (@(posedge mclk) disable iff (reset)
    (run && !mgmt_en_reg) |=> (!mdio_pin.oe_n && mdio_pin.out == $past(link_lost[3])))
    else $error("data pin not showing port 4 link loss");

  link3_status_a: assert property (@(posedge mclk) disable iff (reset)
    (run && !mgmt_en_reg) |=> (!int_pin.oe_n && int_pin.out == $past(link_lost[2])))
    else $error("interrupt pin not showing port 3 link loss");

  int_drain_a: assert property (@(posedge mclk) disable iff (reset)
    (run && mgmt_en_reg) |=> (int_pin.out == 1'b0) && (int_pin.oe_n == (int_pending == '0)))
    else $error("interrupt pin not open-drain or not tracking pending");

  link_evt_a: assert property (@(posedge mclk) disable iff (reset)
    (link_chg != '0) |=> ((int_pending[3:0] & $past(link_chg)) == $past(link_chg)))
    else $error("link change lost");

  jab_evt_a: assert property (@(posedge mclk) disable iff (reset)
    (jabber[0] && !jab_prev_reg[0]) |=> int_pending[QPSM_EVT_JAB_LSB] ##1
      (int_pending[QPSM_EVT_JAB_LSB] || $past(int_clear[QPSM_EVT_JAB_LSB])))
    else $error("jabber event lost");

  link12_out_a: assert property (@(posedge mclk) disable iff (reset)
    run |=> (link2_pin == $past(link_lost[1])) && !link1_pin.oe_n &&
      (link1_pin.out == $past(link_lost[0])))
    else $error("port 1 or 2 status wrong");

  idle_level_a: assert property (@(posedge mclk) disable iff (reset)
    sample |=> (rxd_idle_high == !$past(pad_sync[1])) && run)
    else $error("idle level not taken from strap");

  strap_hold_a: assert property (@(posedge mclk) disable iff (reset)
    run |=> run && $stable(mgmt_en_reg) && $stable(idle_high_reg))
    else $error("strap configuration changed after capture");

  int_release_a: assert property (@(posedge mclk) disable iff (reset)
    (run && mgmt_en_reg && int_pending != '0 && pend_next == '0) |=> int_pin.oe_n)
    else $error("interrupt pin held after causes cleared");

endmodule // qpsm_pins

// ---- hdl/qpsm_sync.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// two-stage synchroniser for pad inputs
// ------------------------------------------------------------------
module qpsm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // first stage, read only by the second stage
  logic [WIDTH-1:0] meta_reg;

  // both stages reset to zero; callers gate strap use until settled, the data bit goes out at once
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // qpsm_sync

// ---- include/qpsm_pkg.sv ----
package qpsm_pkg;

  // ----------------------------------------------------------------
  // port count and event layout
  // ----------------------------------------------------------------
  localparam int QPSM_PORTS = 4;
  // pending vector: [3:0] link change ports 1..4, [7:4] jabber ports 1..4
  localparam int QPSM_EVT_W = 2 * QPSM_PORTS;
  localparam int QPSM_EVT_LINK_LSB = 0;
  localparam int QPSM_EVT_JAB_LSB = 4;

  // ----------------------------------------------------------------
  // strap capture timing and reset values
  // ----------------------------------------------------------------
  // cycles after reset release before the synchronised straps are trusted
  localparam logic [1:0] QPSM_STRAP_SETTLE = 2'h2;
  // management enabled is the pulled-up default of the mode strap
  localparam logic QPSM_MGMT_EN_RST = 1'b1;
  // pulled-up port 1 strap selects low idle level
  localparam logic QPSM_IDLE_HIGH_RST = 1'b0;
  localparam logic [QPSM_EVT_W-1:0] QPSM_PEND_RST = 8'h00;
  localparam logic [QPSM_PORTS-1:0] QPSM_LINK_RST = 4'h0;

  // ----------------------------------------------------------------
  // strap sequencer states, gray along wait -> sample -> run
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    QPSM_ST_WAIT = 2'b00,
    QPSM_ST_SAMPLE = 2'b01,
    QPSM_ST_RUN = 2'b11
  } qpsm_state_e;

  // ----------------------------------------------------------------
  // pad drive pair; oe_n low while the pad is driven
  // ----------------------------------------------------------------
  typedef struct packed {
    logic out;
    logic oe_n;
  } qpsm_pin_s;

  localparam qpsm_pin_s QPSM_PIN_RELEASED = 2'b01;

endpackage

// ---- verification/qpsm_board.sv ----
`timescale 1ns/1ps
// ------------------------------------------
// board side: controller, pull-ups, straps
// ------------------------------------------
module qpsm_board
  import qpsm_pkg::*;
(
  input wire qpsm_pkg::qpsm_pin_s mdio_pin,
  input wire qpsm_pkg::qpsm_pin_s int_pin,
  input wire qpsm_pkg::qpsm_pin_s link1_pin,
  input wire logic ctl_en,
  input wire logic ctl_bit,
  input wire logic strap_low,
  output logic mdio_pad,
  output logic int_pad,
  output logic link1_pad
);
  // shared data line, pull-up when idle
  assign mdio_pad = !mdio_pin.oe_n ? mdio_pin.out : (ctl_en ? ctl_bit : 1'b1);
  assign int_pad = int_pin.oe_n ? 1'b1 : int_pin.out;
  assign link1_pad = link1_pin.oe_n ? !strap_low : link1_pin.out;
endmodule // qpsm_board

// ---- verification/tb.sv ----
`timescale 1ns/1ps
// ------------------------------------------
// pin mux bench against a reference model
// ------------------------------------------
module tb;
  import qpsm_pkg::*;
  logic mclk = 1'b0; // system clock
  logic reset = 1'b1; // asynchronous, active high
  logic [3:0] link_lost, jabber; // per-port status
  logic [7:0] int_clear, int_pending, pend; // clears, seen and expected
  logic tx, tx_en, mode, ctl_en, ctl_bit, strap_low; // stimulus
  logic mdio_pad, int_pad, link1_pad, mgmt_data_rx; // pads
  logic mgmt_enabled, rxd_idle_high, strap_done, link2_pin;
  qpsm_pin_s mdio_pin, int_pin, link1_pin, mdx, inx, l1x;
  logic mgm, idl, l2x, s1, rxe; // expected state
  logic [3:0] plink, pjab; // previous input levels
  logic [31:0] r; // random word
  int cnt, errors = 0, cmp_count = 0;
  integer seed = 32'h0d77;
  always #5 mclk = ~mclk;
  qpsm_pins u_dut (.mclk, .reset, .link_lost, .jabber, .int_clear, .int_pending,
    .mgmt_data_tx(tx), .mgmt_data_tx_en(tx_en), .mgmt_data_rx, .mgmt_enabled,
    .rxd_idle_high, .strap_done, .mode_strap_pin(mode), .mdio_pin_in(mdio_pad),
    .mdio_pin, .int_pin, .link1_pin_in(link1_pad), .link1_pin, .link2_pin);
  qpsm_board u_board (.mdio_pin, .int_pin, .link1_pin, .ctl_en, .ctl_bit,
    .strap_low, .mdio_pad, .int_pad, .link1_pad);
  // ------------------------------------------
  // reference model, one update per edge
  // ------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt = 0;
      {plink, pjab, pend} = 16'h0000;
      {mgm, idl, s1, rxe} = 4'h8;
      {mdx, inx, l1x} = {3{QPSM_PIN_RELEASED}};
      l2x = 1'b0;
    end else begin
      cnt = cnt + 1;
      rxe = s1;
      s1 = !mdx.oe_n ? mdx.out : (ctl_en ? ctl_bit : 1'b1);
      pend = (pend & ~int_clear) | {jabber & ~pjab, link_lost ^ plink};
      {plink, pjab} = {link_lost, jabber};
      if (cnt == 4) begin
        {mgm, idl} = {mode, strap_low};
      end
      // port 2 status follows from the first edge
      l2x = link_lost[1];
      if (cnt >= 5) begin
        mdx = mgm ? {tx, !tx_en} : {link_lost[3], 1'b0};
        inx = mgm ? {1'b0, pend == 8'h00} : {link_lost[2], 1'b0};
        l1x = {link_lost[0], 1'b0};
      end
    end
  end
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // compare, then drive fresh random inputs
  task automatic step(int n);
    repeat (n) begin
      @(negedge mclk);
      chk(int_pending, pend);
      chk(mgmt_enabled, mgm);
      chk(rxd_idle_high, idl);
      chk(strap_done, cnt >= 4);
      chk(mgmt_data_rx, rxe);
      chk(mdio_pin, mdx);
      chk(int_pin, inx);
      chk(link1_pin, l1x);
      chk(link2_pin, l2x);
      chk(int_pad, inx.oe_n ? 1'b1 : inx.out);
      r = $random(seed);
      link_lost <= link_lost ^ (r[7:4] & r[11:8] & r[15:12] & r[19:16]);
      jabber <= jabber ^ (r[23:20] & r[27:24] & r[31:28] & r[19:16]);
      int_clear <= 8'($random(seed)) | 8'($random(seed));
      tx <= r[2];
      tx_en <= r[0];
      // controller talks only while tx_en holds the management drive off
      ctl_en <= !tx_en && !r[0] && r[1];
      // one bit per 400 ns after reset, one per clock while reset holds cnt at 0
      if (cnt % 40 == 0) ctl_bit <= r[3];
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one reset per strap pairing, second one mid-run
  task automatic phase(logic m, logic s, int hold);
    reset <= 1'b1;
    {mode, strap_low} <= {m, s};
    // later resets are held for 160 clocks, the first for 12
    step(hold);
    reset <= 1'b0;
    step(300);
  endtask
  initial begin
    {link_lost, jabber, int_clear, tx, tx_en, ctl_en, ctl_bit} = '0;
    {mode, strap_low} = 2'b11;
    phase(1'b1, 1'b1, 12);
    phase(1'b0, 1'b0, 160);
    phase(1'b1, 1'b0, 160);
    test_done;
  end
  // watchdog, about twice the planned run
  initial begin
    #25000;
    errors++;
    test_done;
  end
endmodule // tb
